//--- hw/flash_ctrl_pkg.sv
/*
  constants for the parallel nor flash host controller: pin encodings, timing figures
  and cycle counts derived from the 100 mhz mclk.
  assumes mclk at 10 ns; timing figures are plain defaults for the flash speed grade.
*/
package flash_ctrl_pkg;
  // ----------------------------------------------------------------
  // clock
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 10;
  // ----------------------------------------------------------------
  // timing figures in ns
  // ----------------------------------------------------------------
  localparam int SELECT_ACCESS_NS  = 70;
  localparam int ADDR_ACCESS_NS    = 70;
  localparam int WRITE_PULSE_NS    = 35;
  localparam int WRITE_HIGH_NS     = 30;
  localparam int RESET_PULSE_NS    = 500;
  localparam int RESET_RECOVERY_NS = 50;
  localparam int READY_EMBED_NS    = 20000;
  localparam int READY_IDLE_NS     = 500;
  localparam int ACCEL_SETUP_NS    = 250;
  // ----------------------------------------------------------------
  // cycle counts: least times round up
  // ----------------------------------------------------------------
  localparam int SELECT_ACCESS_CYC  = (SELECT_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_ACCESS_CYC    = (ADDR_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYC    = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_HIGH_CYC     = (WRITE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PULSE_CYC    = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_RECOVERY_CYC = (RESET_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READY_EMBED_CYC    = (READY_EMBED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READY_IDLE_CYC     = (READY_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCEL_SETUP_CYC    = (ACCEL_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W              = 16;
  // ----------------------------------------------------------------
  // command codes presented by the user
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_READ  = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  // ----------------------------------------------------------------
  // accelerate pin level selects
  // ----------------------------------------------------------------
  localparam logic [1:0] WP_LOW   = 2'h0;
  localparam logic [1:0] WP_HIGH  = 2'h1;
  localparam logic [1:0] WP_ACCEL = 2'h2;
endpackage : flash_ctrl_pkg

//--- hw/flash_delay_cnt.sv
/*
  down counter that loads a cycle count and flags when it has run out.
  assumes the loader holds load for one enabled cycle.
*/
module flash_delay_cnt #(
  parameter int WIDTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] value,
  output logic                  done
);
  logic [WIDTH-1:0] count;

  initial begin
    if (WIDTH < 2) $error("flash_delay_cnt width too small");
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      count <= '0;
    end else if (ce) begin
      if (load) count <= value;
      else if (count != '0) count <= count - WIDTH'(1);
    end
  end

  // ----------------------------------------------------------------
  // expiry flag
  // ----------------------------------------------------------------
  assign done = (count == '0) && !load;
endmodule : flash_delay_cnt

//--- hw/flash_host_ctrl.sv
/*
  host side controller for an asynchronous parallel nor flash: read cycles, write
  cycles, hardware reset pulse with ready wait, and accelerate pin control.
  assumes the flash pins are sampled synchronously to mclk and the board converts
  the accelerate level select into the pin voltage.
*/
module flash_host_ctrl #(
  parameter int ADDR_W      = 22,
  parameter int DATA_W      = 16,
  parameter int READY_EMBED = flash_ctrl_pkg::READY_EMBED_CYC
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              req_valid,
  input  wire logic [1:0]        req_op,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  input  wire logic              reset_req,
  input  wire logic              accel_req,
  input  wire logic              protect_req,
  output logic                   accel_active,
  output logic                   resume_needed,
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n,
  output logic                   flash_reset_n,
  output logic [1:0]             write_protect_accel_pin,
  output logic [ADDR_W-1:0]      flash_addr,
  input  wire logic [DATA_W-1:0] data_bus_in,
  output logic [DATA_W-1:0]      data_bus_out,
  output logic                   data_bus_oe,
  input  wire logic              ready_busy_n_out
);
  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_IDLE    = 8'b0000_0001,
    ST_RD      = 8'b0000_0010,
    ST_WR_LOW  = 8'b0000_0100,
    ST_WR_HIGH = 8'b0000_1000,
    ST_RST_LOW = 8'b0001_0000,
    ST_RST_RDY = 8'b0010_0000,
    ST_RST_REC = 8'b0100_0000,
    ST_ACC_SET = 8'b1000_0000
  } state_t;

  typedef struct packed {
    state_t            state;
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              reset_n;
    logic [1:0]        wp;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              drive;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
    logic              accel;
    logic              resume;
    logic              load;
    logic [flash_ctrl_pkg::CNT_W-1:0] load_val;
  } regs_t;

  regs_t r;
  regs_t next_r;
  logic  timer_done;

  initial begin
    if (ADDR_W < 1 || ADDR_W > 32) $error("flash_host_ctrl bad address width");
    if (DATA_W != 8 && DATA_W != 16) $error("flash_host_ctrl data width must be 8 or 16");
    if (READY_EMBED < 1 || READY_EMBED >= (1 << flash_ctrl_pkg::CNT_W))
      $error("flash_host_ctrl ready count out of range");
  end

  function automatic logic [flash_ctrl_pkg::CNT_W-1:0] cyc(input int n);
    cyc = flash_ctrl_pkg::CNT_W'(n);
  endfunction : cyc

  flash_delay_cnt #(
    .WIDTH (flash_ctrl_pkg::CNT_W)
  ) u_timer (
    .mclk  (mclk),
    .rst   (rst),
    .ce    (ce),
    .load  (r.load),
    .value (r.load_val),
    .done  (timer_done)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r        = r;
    next_r.load   = 1'b0;
    next_r.rvalid = 1'b0;
    case (r.state)
      ST_IDLE: begin
        if (reset_req) begin
          next_r.reset_n  = 1'b0;
          next_r.ce_n     = 1'b1;
          next_r.oe_n     = 1'b1;
          next_r.we_n     = 1'b1;
          next_r.drive    = 1'b0;
          next_r.resume   = !ready_busy_n_out;
          next_r.load     = 1'b1;
          next_r.load_val = cyc(flash_ctrl_pkg::RESET_PULSE_CYC);
          next_r.state    = ST_RST_LOW;
        end else if (accel_req != r.accel) begin
          // voltage only while accelerated programming is requested
          next_r.wp       = accel_req ? flash_ctrl_pkg::WP_ACCEL
                          : (protect_req ? flash_ctrl_pkg::WP_LOW
                                         : flash_ctrl_pkg::WP_HIGH);
          next_r.accel    = accel_req;
          next_r.load     = 1'b1;
          next_r.load_val = cyc(flash_ctrl_pkg::ACCEL_SETUP_CYC);
          next_r.state    = ST_ACC_SET;
        end else if (req_valid) begin
          next_r.addr  = req_addr;
          next_r.ce_n  = 1'b0;
          next_r.load  = 1'b1;
          if (req_op == flash_ctrl_pkg::OP_WRITE) begin
            next_r.we_n     = 1'b0;
            next_r.oe_n     = 1'b1;
            next_r.wdata    = req_wdata;
            next_r.drive    = 1'b1;
            next_r.load_val = cyc(flash_ctrl_pkg::WRITE_PULSE_CYC);
            next_r.state    = ST_WR_LOW;
          end else begin
            next_r.oe_n     = 1'b0;
            next_r.we_n     = 1'b1;
            next_r.load_val = cyc(flash_ctrl_pkg::SELECT_ACCESS_CYC);
            next_r.state    = ST_RD;
          end
        end else begin
          if (!r.accel) begin
            next_r.wp = protect_req ? flash_ctrl_pkg::WP_LOW : flash_ctrl_pkg::WP_HIGH;
          end
        end
      end
      ST_RD: begin
        if (timer_done) begin
          next_r.rdata  = data_bus_in;
          next_r.rvalid = 1'b1;
          next_r.ce_n   = 1'b1;
          next_r.oe_n   = 1'b1;
          next_r.state  = ST_IDLE;
        end
      end
      ST_WR_LOW: begin
        if (timer_done) begin
          next_r.we_n     = 1'b1;
          next_r.ce_n     = 1'b1;
          next_r.load     = 1'b1;
          next_r.load_val = cyc(flash_ctrl_pkg::WRITE_HIGH_CYC);
          next_r.state    = ST_WR_HIGH;
        end
      end
      ST_WR_HIGH: begin
        if (timer_done) begin
          next_r.drive = 1'b0;
          next_r.state = ST_IDLE;
        end
      end
      ST_RST_LOW: begin
        if (timer_done) begin
          next_r.reset_n  = 1'b1;
          next_r.load     = 1'b1;
          next_r.load_val = r.resume ? cyc(READY_EMBED)
                                     : cyc(flash_ctrl_pkg::READY_IDLE_CYC);
          next_r.state    = ST_RST_RDY;
        end
      end
      ST_RST_RDY: begin
        // wait for ready high or the ready time, whichever first
        if (ready_busy_n_out || timer_done) begin
          next_r.load     = 1'b1;
          next_r.load_val = cyc(flash_ctrl_pkg::RESET_RECOVERY_CYC);
          next_r.state    = ST_RST_REC;
        end
      end
      ST_RST_REC: begin
        if (timer_done) next_r.state = ST_IDLE;
      end
      ST_ACC_SET: begin
        if (timer_done) next_r.state = ST_IDLE;
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase
    if (r.state == ST_IDLE && !reset_req && accel_req == r.accel && req_valid) begin
      next_r.resume = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      r.state    <= ST_IDLE;
      r.ce_n     <= 1'b1;
      r.oe_n     <= 1'b1;
      r.we_n     <= 1'b1;
      r.reset_n  <= 1'b1;
      r.wp       <= flash_ctrl_pkg::WP_LOW;
      r.addr     <= '0;
      r.wdata    <= '0;
      r.drive    <= 1'b0;
      r.rdata    <= '0;
      r.rvalid   <= 1'b0;
      r.accel    <= 1'b0;
      r.resume   <= 1'b0;
      r.load     <= 1'b0;
      r.load_val <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign req_ready               = (r.state == ST_IDLE) && !reset_req && (accel_req == r.accel);
  assign rsp_valid               = r.rvalid;
  assign rsp_rdata               = r.rdata;
  assign accel_active            = r.accel;
  assign resume_needed           = r.resume;
  assign flash_ce_n              = r.ce_n;
  assign flash_oe_n              = r.oe_n;
  assign flash_we_n              = r.we_n;
  assign flash_reset_n           = r.reset_n;
  assign write_protect_accel_pin = r.wp;
  assign flash_addr              = r.addr;
  assign data_bus_out            = r.wdata;
  assign data_bus_oe             = r.drive;
endmodule : flash_host_ctrl

//--- sim/flash_host_ctrl_assertions.sv
/*
  pin-level assertions for the flash host controller.
  assumes binding to flash_host_ctrl; one clock mclk, sync reset rst.
*/
module flash_host_ctrl_assertions (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       rsp_valid,
  input wire logic       accel_active,
  input wire logic       flash_ce_n,
  input wire logic       flash_oe_n,
  input wire logic       flash_we_n,
  input wire logic       flash_reset_n,
  input wire logic [1:0] write_protect_accel_pin,
  input wire logic       data_bus_oe
);
  logic [6:0] low_cnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // length of the reset pulse so far, saturating
  always_ff @(posedge mclk) begin
    if (rst || flash_reset_n) begin
      low_cnt <= 7'h0;
    end else if (low_cnt != 7'h7f) begin
      low_cnt <= low_cnt + 7'h1;
    end
  end
  property p_rd_pins; !flash_oe_n |-> !flash_ce_n && flash_we_n; endproperty
  a_rd_pins: assert property (p_rd_pins) else $error("read pins");
  property p_wr_pulse; $fell(flash_we_n) |-> (!flash_we_n && !flash_ce_n && flash_oe_n)[*4];
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse");
  property p_bus; data_bus_oe |-> flash_oe_n; endproperty
  a_bus: assert property (p_bus) else $error("bus clash");
  property p_accel; write_protect_accel_pin == flash_ctrl_pkg::WP_ACCEL |-> accel_active;
  endproperty
  a_accel: assert property (p_accel) else $error("accel level");
  property p_rst_len;
    $rose(flash_reset_n) |-> low_cnt >= 7'(flash_ctrl_pkg::RESET_PULSE_CYC);
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset short");
  property p_rst_quiet; !flash_reset_n |-> flash_ce_n && flash_we_n && flash_oe_n; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("reset busy");
  property p_recov; $rose(flash_reset_n) |-> (flash_oe_n && flash_we_n)[*5]; endproperty
  a_recov: assert property (p_recov) else $error("recovery");
  property p_rd_time; $fell(flash_oe_n) |-> (!flash_oe_n)[*7] ##[1:3] rsp_valid; endproperty
  a_rd_time: assert property (p_rd_time) else $error("read time");
endmodule : flash_host_ctrl_assertions

bind flash_host_ctrl flash_host_ctrl_assertions i_flash_host_ctrl_assertions (
  .mclk, .rst, .rsp_valid, .accel_active, .flash_ce_n, .flash_oe_n, .flash_we_n,
  .flash_reset_n, .write_protect_accel_pin, .data_bus_oe
);

//--- sim/flash_dev_model.sv
/*
  behavioural parallel nor flash: 16 words, word 0 protected unless accelerated.
  assumes pins sampled on mclk; a write keeps it busy for 40 cycles.
*/
module flash_dev_model (
  input  wire logic        mclk,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        reset_n,
  input  wire logic [1:0]  write_protect_accel_pin,
  input  wire logic [21:0] addr,
  input  wire logic [15:0] host_data,
  output logic [15:0]      dev_data,
  output logic             ready_busy_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [16];
  logic [15:0] last = 16'h0;
  logic        we_d = 1'b1;
  logic        drive;
  logic        valid;
  int          acc_cnt = 0;
  int          busy_cnt = 0;
  initial begin
    foreach (mem[i]) begin
      mem[i] = 16'hffff;
    end
  end
  assign drive = reset_n && !ce_n && !oe_n;
  // reads go on while busy; until access time is met the bus shows junk
  assign valid = drive && acc_cnt >= flash_ctrl_pkg::SELECT_ACCESS_CYC - 1;
  assign dev_data = valid ? mem[addr[3:0]] : ~last;
  assign ready_busy_n_out = (busy_cnt == 0);
  always @(posedge mclk) begin
    we_d <= we_n;
    if (valid) begin
      last <= dev_data;
    end
    if (!reset_n) begin
      acc_cnt <= 0;
      if (busy_cnt > 0) begin
        busy_cnt <= 8;
      end
    end else begin
      acc_cnt <= drive ? acc_cnt + 1 : 0;
      if (!ce_n && !we_n && we_d) begin
        if (addr[3:0] != 4'h0 || write_protect_accel_pin == flash_ctrl_pkg::WP_ACCEL) begin
          mem[addr[3:0]] <= host_data;
        end
        busy_cnt <= 40;
      end else if (busy_cnt > 0) begin
        busy_cnt <= busy_cnt - 1;
      end
    end
  end
endmodule : flash_dev_model

//--- sim/flash_host_ctrl_test.sv
/*
  self-checking bench for flash_host_ctrl against the flash model.
  assumes flash_dev_model and the bound checker are compiled alongside.
*/
module flash_host_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        req_valid = 1'b0;
  logic [1:0]  req_op = 2'h0;
  logic [21:0] req_addr = 22'h0;
  logic [15:0] req_wdata = 16'h0;
  logic        reset_req = 1'b0;
  logic        accel_req = 1'b0;
  logic        protect_req = 1'b0;
  logic        req_ready, rsp_valid, accel_active, resume_needed;
  logic        ce_n, oe_n, we_n, reset_n, data_bus_oe, rdy;
  logic [1:0]  wp;
  logic [21:0] addr;
  logic [15:0] rsp_rdata, dout, din, q;
  int          error_cnt = 0;
  int          n_checks = 0;
  always #5 mclk = ~mclk;
  flash_host_ctrl #(.READY_EMBED(20)) i_flash_host_ctrl (
    .mclk, .rst, .ce(1'b1), .req_valid, .req_op, .req_addr, .req_wdata, .req_ready,
    .rsp_valid, .rsp_rdata, .reset_req, .accel_req, .protect_req, .accel_active,
    .resume_needed, .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_reset_n(reset_n), .write_protect_accel_pin(wp), .flash_addr(addr),
    .data_bus_in(din), .data_bus_out(dout), .data_bus_oe, .ready_busy_n_out(rdy));
  flash_dev_model i_flash_dev_model (
    .mclk, .ce_n, .oe_n, .we_n, .reset_n, .write_protect_accel_pin(wp), .addr,
    .host_data(data_bus_oe ? dout : ~dout), .dev_data(din), .ready_busy_n_out(rdy));
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // poll a flag at falling edges, bounded
  task automatic wait_hi(ref logic flag, input int lim);
    int i;
    i = 0;
    @(negedge mclk);
    while (flag !== 1'b1 && i < lim) begin
      @(negedge mclk);
      i++;
    end
    if (flag !== 1'b1) begin
      error_cnt++;
      stop_test();
    end
  endtask : wait_hi
  task automatic xfer(input logic [1:0] op, input logic [21:0] a, input logic [15:0] d);
    wait_hi(req_ready, 400);
    @(posedge mclk);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_wdata <= d;
    @(posedge mclk);
    req_valid <= 1'b0;
    if (op == flash_ctrl_pkg::OP_READ) begin
      wait_hi(rsp_valid, 50);
      q = rsp_rdata;
    end
  endtask : xfer
  task automatic pulse_reset();
    int i;
    i = 0;
    @(posedge mclk);
    reset_req <= 1'b1;
    @(negedge mclk);
    // hold the request until the controller has taken it
    while (reset_n !== 1'b0 && i < 400) begin
      @(negedge mclk);
      i++;
    end
    if (reset_n !== 1'b0) begin
      error_cnt++;
      stop_test();
    end
    @(posedge mclk);
    reset_req <= 1'b0;
    wait_hi(req_ready, 400);
  endtask : pulse_reset
  task automatic s_rw();
    xfer(flash_ctrl_pkg::OP_WRITE, 22'h5, 16'h1234);
    xfer(flash_ctrl_pkg::OP_WRITE, 22'h6, 16'hbeef);
    xfer(flash_ctrl_pkg::OP_READ, 22'h5, 16'h0);
    chk(q, 16'h1234);
    xfer(flash_ctrl_pkg::OP_READ, 22'h6, 16'h0);
    chk(q, 16'hbeef);
    xfer(flash_ctrl_pkg::OP_READ, 22'h7, 16'h0);
    chk(q, 16'hffff);
  endtask : s_rw
  task automatic s_accel();
    @(posedge mclk);
    protect_req <= 1'b1;
    xfer(flash_ctrl_pkg::OP_WRITE, 22'h0, 16'h5a5a);
    chk({14'h0, wp}, {14'h0, flash_ctrl_pkg::WP_LOW});
    xfer(flash_ctrl_pkg::OP_READ, 22'h0, 16'h0);
    chk(q, 16'hffff);
    @(posedge mclk);
    accel_req <= 1'b1;
    xfer(flash_ctrl_pkg::OP_WRITE, 22'h0, 16'h5a5a);
    chk({14'h0, wp}, {14'h0, flash_ctrl_pkg::WP_ACCEL});
    xfer(flash_ctrl_pkg::OP_READ, 22'h0, 16'h0);
    chk(q, 16'h5a5a);
    @(posedge mclk);
    accel_req <= 1'b0;
    protect_req <= 1'b0;
    xfer(flash_ctrl_pkg::OP_WRITE, 22'h0, 16'h0001);
    chk({14'h0, wp}, {14'h0, flash_ctrl_pkg::WP_HIGH});
    xfer(flash_ctrl_pkg::OP_READ, 22'h0, 16'h0);
    chk(q, 16'h5a5a);
  endtask : s_accel
  task automatic s_reset();
    xfer(flash_ctrl_pkg::OP_WRITE, 22'h9, 16'h00a0);
    pulse_reset();
    chk({15'h0, resume_needed}, 16'h1);
    // the cut program is issued again
    xfer(flash_ctrl_pkg::OP_WRITE, 22'h9, 16'h00a0);
    xfer(flash_ctrl_pkg::OP_READ, 22'h9, 16'h0);
    chk(q, 16'h00a0);
    chk({15'h0, resume_needed}, 16'h0);
    wait_hi(rdy, 100);
    pulse_reset();
    chk({15'h0, resume_needed}, 16'h0);
    chk({15'h0, accel_active}, 16'h0);
  endtask : s_reset
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    s_rw();
    s_accel();
    s_reset();
    stop_test();
  end
endmodule : flash_host_ctrl_test
